// file: tb/cdm_mem_model.sv
// memory partner: one shared req/ack bus holding program and data bytes
// assumes the core holds its request steady until the ack edge
`timescale 1ns/1ps
module cdm_mem_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_bus_req,
  input  wire logic        i_bus_we,
  input  wire logic [31:0] i_bus_addr,
  input  wire logic [1:0]  i_bus_size,
  input  wire logic [31:0] i_bus_wdata,
  output logic      [31:0] o_bus_rdata,
  output logic             o_bus_ack
);
  logic [7:0] mem [0:255];
  int         wait_cyc;
  int         cnt;
  int         n_acc;
  int         n_bad;
  logic [7:0] a;

  initial begin
    o_bus_rdata = 32'h5a5a_5a5a;
    o_bus_ack   = 1'b0;
    wait_cyc    = 0;
  end

  // answer after wait_cyc idle cycles; big-endian, right-justified data
  always @(negedge i_ref_clk or posedge i_rst) begin
    a = i_bus_addr[7:0];
    if (i_rst) begin
      o_bus_ack <= 1'b0;
      cnt = 0;
      n_acc = 0;
      n_bad = 0;
    end else if (o_bus_ack) begin
      o_bus_ack   <= 1'b0;
      o_bus_rdata <= ~o_bus_rdata; // released data does not linger
      cnt = 0;
    end else if (i_bus_req && cnt < wait_cyc) begin
      cnt = cnt + 1; // slow memory stretches every access
    end else if (i_bus_req) begin
      o_bus_ack <= 1'b1;
      n_acc = n_acc + 1;
      if ((i_bus_size == 2'h1 && a[0]) || i_bus_size == 2'h3 ||
          (i_bus_size == 2'h2 && a[1:0] != 2'h0))
        n_bad = n_bad + 1;
      if (i_bus_we && i_bus_size == 2'h2)
        {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]} = i_bus_wdata;
      else if (i_bus_we && i_bus_size == 2'h1)
        {mem[a], mem[a+8'h1]} = i_bus_wdata[15:0];
      else if (i_bus_we)
        mem[a] = i_bus_wdata[7:0];
      else if (i_bus_size == 2'h2)
        o_bus_rdata <= {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]};
      else if (i_bus_size == 2'h1)
        o_bus_rdata <= {16'h0000, mem[a], mem[a+8'h1]};
      else
        o_bus_rdata <= {24'h000000, mem[a]};
    end
  end
endmodule

// file: tb/cdm_move_core_test.sv
// self-checking bench: small programs run from the memory partner
// assumes every program ends in power-down so a run has a clear end
`timescale 1ns/1ps
module cdm_move_core_test;
  logic        i_ref_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_wake    = 1'b0;
  logic [31:0] bus_rdata;
  logic        bus_ack;
  logic        bus_req;
  logic        bus_we;
  logic [31:0] bus_addr;
  logic [1:0]  bus_size;
  logic [31:0] bus_wdata;
  logic        t_flag;
  logic [31:0] pc;
  logic        sleep;
  logic        addr_err;
  int          err_count = 0;
  int          checks    = 0;
  int          n_aerr    = 0;
  logic [15:0] pq [$];

  always #50 i_ref_clk = ~i_ref_clk;

  cdm_move_core u_cdm_move_core (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_bus_rdata (bus_rdata),
    .i_bus_ack   (bus_ack),
    .i_wake      (i_wake),
    .o_bus_req   (bus_req),
    .o_bus_we    (bus_we),
    .o_bus_addr  (bus_addr),
    .o_bus_size  (bus_size),
    .o_bus_wdata (bus_wdata),
    .o_pc        (pc),
    .o_t_flag    (t_flag),
    .o_sleep     (sleep),
    .o_addr_err  (addr_err)
  );

  cdm_mem_model u_cdm_mem_model (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_bus_req   (bus_req),
    .i_bus_we    (bus_we),
    .i_bus_addr  (bus_addr),
    .i_bus_size  (bus_size),
    .i_bus_wdata (bus_wdata),
    .o_bus_rdata (bus_rdata),
    .o_bus_ack   (bus_ack)
  );

  // count skipped misaligned accesses
  always @(negedge i_ref_clk) if (addr_err === 1'b1) n_aerr++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] m32(input int a);
    return {u_cdm_mem_model.mem[a], u_cdm_mem_model.mem[a+1],
            u_cdm_mem_model.mem[a+2], u_cdm_mem_model.mem[a+3]};
  endfunction

  task automatic p32(input int a, input logic [31:0] v);
    {u_cdm_mem_model.mem[a], u_cdm_mem_model.mem[a+1],
     u_cdm_mem_model.mem[a+2], u_cdm_mem_model.mem[a+3]} = v;
  endtask

  task automatic clr;
    foreach (u_cdm_mem_model.mem[k]) u_cdm_mem_model.mem[k] = 8'h00;
  endtask

  // load pq at address zero, reset the core and run until power-down
  task automatic run(input int ws, output int cyc);
    foreach (pq[k]) begin
      u_cdm_mem_model.mem[2*k]   = pq[k][15:8];
      u_cdm_mem_model.mem[2*k+1] = pq[k][7:0];
    end
    u_cdm_mem_model.wait_cyc = ws;
    cyc = 0;
    @(negedge i_ref_clk) i_rst = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    i_rst  = 1'b0;
    n_aerr = 0;
    while (sleep !== 1'b1 && cyc < 3000) begin
      @(negedge i_ref_clk);
      cyc++;
    end
    check(cyc < 3000, 1, "program reaches power-down");
    check(u_cdm_mem_model.n_bad, 0, "misaligned bus access");
  endtask

  task automatic t_imm;
    int c;
    clr();
    pq = '{16'he180, 16'hef40, 16'he27f, 16'h0018, 16'h2f12,
           16'h1f21, 16'h001b};
    run(0, c);
    check(m32('h40), 32'hffffff80, "negative literal");
    check(m32('h44), 32'h0000007f, "positive literal");
    check(t_flag, 1, "flag after moves");
    $display("test imm done");
  endtask

  task automatic t_indirect;
    int c;
    clr();
    p32('h40, 32'h80818283);
    pq = '{16'he140, 16'h6210, 16'h6311, 16'h6412, 16'he550,
           16'h1520, 16'h1531, 16'h1542, 16'h001b};
    run(0, c);
    check(m32('h50), 32'hffffff80, "indirect byte");
    check(m32('h54), 32'hffff8081, "indirect word");
    check(m32('h58), 32'h80818283, "indirect long");
    $display("test indirect done");
  endtask

  task automatic t_step;
    int c;
    clr();
    pq = '{16'he150, 16'he281, 16'h2126, 16'h2125, 16'h2124, 16'h6314,
           16'h6415, 16'h6516, 16'he660, 16'h2612, 16'h6666, 16'he770,
           16'h2762, 16'h1731, 16'h1742, 16'h001b};
    run(0, c);
    check(m32('h4c), 32'hffffff81, "pre-decrement long");
    check(m32('h48), 32'h0081ff81, "pre-decrement word, byte");
    check(m32('h60), 32'h00000050, "source after increments");
    check(m32('h74), 32'hffffff81, "post-increment byte");
    check(m32('h78), 32'hffffff81, "post-increment word");
    check(m32('h70), 32'h00000050, "same register load");
    $display("test step done");
  endtask

  task automatic t_disp;
    int c;
    clr();
    p32('h50, 32'h1122a3b4);
    p32('h54, 32'hc5d6e7f8);
    pq = '{16'he085, 16'he160, 16'h8013, 16'h8113, 16'he250, 16'h8422,
           16'h1102, 16'h8521, 16'h1103, 16'h5321, 16'h1134, 16'h001b};
    run(0, c);
    check(m32('h60), 32'h00000085, "byte disp store");
    check(m32('h64), 32'h0000ff85, "word disp store");
    check(m32('h68), 32'hffffffa3, "byte disp load");
    check(m32('h6c), 32'hffffa3b4, "word disp load");
    check(m32('h70), 32'hc5d6e7f8, "long disp load");
    $display("test disp done");
  endtask

  task automatic t_index_pc;
    int c;
    clr();
    p32('h30, 32'h87650000);
    p32('h34, 32'h12345678);
    pq = '{16'he040, 16'he120, 16'he281, 16'h0126, 16'he124, 16'h0125,
           16'he126, 16'h0124, 16'h930e, 16'hd408, 16'he550, 16'h1530,
           16'h1541, 16'h061d, 16'h1562, 16'h001b};
    run(0, c);
    check(m32('h60), 32'hffffff81, "indexed long");
    check(m32('h58), 32'hffff8100, "indexed word load");
    check(m32('h64), 32'hff818100, "indexed word, byte");
    check(m32('h50), 32'hffff8765, "pc word load");
    check(m32('h54), 32'h12345678, "pc long load");
    $display("test index pc done");
  endtask

  task automatic t_timing;
    int c0;
    int c1;
    int n0;
    int k;
    clr();
    p32('h40, 32'h13579bdf);
    pq = '{16'he140, 16'h0018, 16'h6212, 16'h1121, 16'h001b, 16'h001b};
    run(0, c0);
    n0 = u_cdm_mem_model.n_acc;
    run(3, c1);
    check(c1 - c0, 3 * n0, "wait states add states");
    check(n0, 7, "fetches plus data accesses");
    check(m32('h44), 32'h13579bdf, "dependent store");
    check(t_flag, 1, "flag after load");
    check(pc, 32'h0000000a, "pc parked in power-down");
    k = 0;
    repeat (10) begin
      @(negedge i_ref_clk);
      if (bus_req !== 1'b0) k++;
    end
    check(k, 0, "no bus traffic asleep");
    i_wake = 1'b1;
    k = 0;
    while (bus_req !== 1'b1 && k < 20) begin
      @(negedge i_ref_clk);
      k++;
    end
    i_wake = 1'b0;
    check(bus_addr, 32'h0000000a, "fetch after wake");
    k = 0;
    while (sleep !== 1'b1 && k < 20) begin
      @(negedge i_ref_clk);
      k++;
    end
    check(pc, 32'h0000000c, "asleep again after wake");
    $display("test timing done");
  endtask

  task automatic t_misalign;
    int c;
    clr();
    pq = '{16'he141, 16'h0018, 16'h0008, 16'h6212, 16'h001b};
    run(0, c);
    check(n_aerr, 1, "misaligned pulse");
    check(u_cdm_mem_model.n_acc, 5, "misaligned access skipped");
    check(t_flag, 0, "flag cleared");
    $display("test misalign done");
  endtask

  task automatic t_ret;
    int c;
    clr();
    p32('h40, 32'h00000020);
    p32('h44, 32'h00000001);
    p32('h20, 32'h1ff4001b);
    pq = '{16'hef40, 16'h0008, 16'h002b};
    run(0, c);
    check(t_flag, 1, "flag restored");
    check(m32('h58), 32'h00000048, "resumed with stack popped");
    check(pc, 32'h00000024, "resumed flow parked");
    $display("test return done");
  endtask

  // watchdog: all runs finish well inside this span
  initial begin
    #3_000_000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    t_imm();
    t_indirect();
    t_step();
    t_disp();
    t_index_pc();
    t_timing();
    t_misalign();
    t_ret();
    print_verdict();
  end
endmodule

// file: verilog/cdm_load_ext.sv
// extends right-justified load data from the bus to a full register
// assumes the bus returns byte and word data in the low bits
`timescale 1ns/1ps
module cdm_load_ext (
  input  wire logic [31:0] i_data,
  input  wire logic [1:0]  i_size,
  output logic      [31:0] o_data
);
  // bytes and words sign-extend, longs pass unchanged
  always_comb begin
    case (i_size)
      cdm_pkg::SZ_B: o_data = {{24{i_data[7]}}, i_data[7:0]};
      cdm_pkg::SZ_W: o_data = {{16{i_data[15]}}, i_data[15:0]};
      default:       o_data = i_data;
    endcase
  end
endmodule

// file: verilog/cdm_move_core.sv
// data-move core: fetch, decode and execute of register and memory moves
// assumes a single memory bus that acks each request with a one-cycle pulse
`timescale 1ns/1ps
module cdm_move_core #(
  parameter logic [31:0] RESET_PC = cdm_pkg::RESET_PC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [31:0] i_bus_rdata,
  input  wire logic        i_bus_ack,
  input  wire logic        i_wake,
  output logic             o_bus_req,
  output logic             o_bus_we,
  output logic      [31:0] o_bus_addr,
  output logic      [1:0]  o_bus_size,
  output logic      [31:0] o_bus_wdata,
  output logic      [31:0] o_pc,
  output logic             o_t_flag,
  output logic             o_sleep,
  output logic             o_addr_err
);
  typedef struct packed {
    cdm_pkg::cdm_state_t st;
    logic [31:0]         pc;
    logic [15:0]         ir;
    logic                t;
    logic                sleep;
    logic                req;
    logic                we;
    logic [31:0]         addr;
    logic [1:0]          size;
    logic [31:0]         wdata;
    logic [3:0]          ld_dst;
    logic                eret;
    logic                aerr;
    logic                wb_en;
    logic [3:0]          wb_addr;
    logic [31:0]         wb_data;
  } cdm_core_state_t;

  cdm_core_state_t s_q;
  cdm_core_state_t s_d;
  logic [95:0]     rd_data;
  logic [31:0]     zero_v;
  logic [31:0]     dst_v;
  logic [31:0]     src_v;
  logic [31:0]     ld_ext;
  logic            rd_en;
  logic [3:0]      rd_m;
  logic [3:0]      top;
  logic [3:0]      fn;
  logic [3:0]      fm;
  logic [3:0]      flo;

  // instruction fields, leftmost printed bit is bit 15
  assign top = s_q.ir[cdm_pkg::F_TOP -: 4];
  assign fn  = s_q.ir[cdm_pkg::F_N -: 4];
  assign fm  = s_q.ir[cdm_pkg::F_M -: 4];
  assign flo = s_q.ir[cdm_pkg::F_LO -: 4];

  // operands are read while the fetched word arrives
  assign rd_en = (s_q.st == cdm_pkg::ST_FETCH) && s_q.req && i_bus_ack;
  assign rd_m   = (i_bus_rdata[15:0] == cdm_pkg::SYS_ERET) ?
                  cdm_pkg::REG_STACK : i_bus_rdata[cdm_pkg::F_M -: 4];
  assign zero_v = rd_data[31:0];
  assign dst_v  = rd_data[63:32];
  assign src_v  = rd_data[95:64];

  cdm_reg_file #(
    .WIDTH (32),
    .AW    (4),
    .NRD   (3)
  ) u_regs (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_rd_en   (rd_en),
    .i_rd_addr ({rd_m, i_bus_rdata[cdm_pkg::F_N -: 4], cdm_pkg::REG_ZERO}),
    .o_rd_data (rd_data),
    .i_wr_en   (s_d.wb_en),
    .i_wr_addr (s_d.wb_addr),
    .i_wr_data (s_d.wb_data)
  );

  cdm_load_ext u_ext (
    .i_data (i_bus_rdata),
    .i_size (s_q.size),
    .o_data (ld_ext)
  );

  // next-state logic of the whole core
  always_comb begin
    logic        acc;
    logic        st;
    logic        upd;
    logic        wr;
    logic        mis;
    logic [1:0]  sz;
    logic [31:0] a;
    logic [31:0] wd;
    logic [31:0] uv;
    logic [31:0] step;
    logic [3:0]  dst;
    logic [3:0]  ua;
    acc  = 1'b0;
    st   = 1'b0;
    upd  = 1'b0;
    wr   = 1'b0;
    mis  = 1'b0;
    sz   = cdm_pkg::SZ_L;
    a    = '0;
    wd   = src_v;
    uv   = '0;
    step = '0;
    dst  = fn;
    ua   = fn;
    s_d       = s_q;
    s_d.wb_en = 1'b0;
    s_d.aerr  = 1'b0;
    case (s_q.st)
      cdm_pkg::ST_FETCH: begin
        // fetch shares the bus with data, so it waits its turn
        if (!s_q.req) begin
          s_d.req  = 1'b1;
          s_d.we   = 1'b0;
          s_d.addr = s_q.pc;
          s_d.size = cdm_pkg::SZ_W;
        end else if (i_bus_ack) begin
          s_d.req = 1'b0;
          s_d.ir  = i_bus_rdata[15:0];
          s_d.st  = cdm_pkg::ST_EXEC;
        end
      end
      cdm_pkg::ST_EXEC: begin
        s_d.pc = s_q.pc + cdm_pkg::INSN_STEP;
        s_d.st = cdm_pkg::ST_FETCH;
        case (top)
          cdm_pkg::OP_IMM: begin
            wr = 1'b1;
            uv = {{24{s_q.ir[7]}}, s_q.ir[7:0]};
          end
          cdm_pkg::OP_PCW: begin
            acc = 1'b1;
            sz  = cdm_pkg::SZ_W;
            a   = s_q.pc + cdm_pkg::PC_OFS
                  + ({24'h0, s_q.ir[7:0]} << 1);
          end
          cdm_pkg::OP_PCL: begin
            acc = 1'b1;
            a   = ((s_q.pc + cdm_pkg::PC_OFS) & cdm_pkg::LONG_MASK)
                  + ({24'h0, s_q.ir[7:0]} << 2);
          end
          cdm_pkg::OP_LDI: begin
            if (flo == cdm_pkg::LO_MOVR) begin
              wr = 1'b1;
              uv = src_v;
            end else if (flo[1:0] != 2'h3 && !flo[3]) begin
              acc = 1'b1;
              sz  = flo[1:0];
              a   = src_v;
              upd = (flo[3:2] == cdm_pkg::LG_STEP);
              ua  = fm;
            end
          end
          cdm_pkg::OP_STI: begin
            if (flo[1:0] != 2'h3 && flo[3:2] <= cdm_pkg::LG_STEP) begin
              acc = 1'b1;
              st  = 1'b1;
              sz  = flo[1:0];
              a   = dst_v;
              upd = (flo[3:2] == cdm_pkg::LG_STEP);
            end
          end
          cdm_pkg::OP_STLD: begin
            acc = 1'b1;
            st  = 1'b1;
            a   = dst_v + ({28'h0, flo} << 2);
          end
          cdm_pkg::OP_LDLD: begin
            acc = 1'b1;
            a   = src_v + ({28'h0, flo} << 2);
          end
          cdm_pkg::OP_DBW: begin
            if (fn == cdm_pkg::DBW_STB || fn == cdm_pkg::DBW_STW) begin
              acc = 1'b1;
              st  = 1'b1;
              wd  = zero_v;
              sz  = fn[1:0];
              a   = src_v + ({28'h0, flo} << fn[1:0]);
            end else if (fn == cdm_pkg::DBW_LDB
                         || fn == cdm_pkg::DBW_LDW) begin
              acc = 1'b1;
              sz  = fn[1:0];
              dst = cdm_pkg::REG_ZERO;
              a   = src_v + ({28'h0, flo} << fn[1:0]);
            end
          end
          cdm_pkg::OP_IDX: begin
            if (flo[1:0] != 2'h3 && flo[3:2] == cdm_pkg::LG_STEP) begin
              acc = 1'b1;
              st  = 1'b1;
              sz  = flo[1:0];
              a   = zero_v + dst_v;
            end else if (flo[1:0] != 2'h3
                         && flo[3:2] == cdm_pkg::LG_IDXLD) begin
              acc = 1'b1;
              sz  = flo[1:0];
              a   = zero_v + src_v;
            end else if (s_q.ir == cdm_pkg::SYS_TCLR) begin
              s_d.t = 1'b0;
            end else if (s_q.ir == cdm_pkg::SYS_TSET) begin
              s_d.t = 1'b1;
            end else if (s_q.ir == cdm_pkg::SYS_SLEEP) begin
              s_d.sleep = 1'b1;
              s_d.st    = cdm_pkg::ST_SLEEP;
            end else if (s_q.ir == cdm_pkg::SYS_ERET) begin
              acc      = 1'b1;
              a        = src_v;
              s_d.eret = 1'b1;
            end
          end
          default: begin
          end
        endcase
        // step of 1, 2 or 4 and the natural alignment check
        step = 32'h1 << sz;
        if (upd && st) begin
          a = dst_v - step;
        end
        uv  = upd ? (st ? a : src_v + step) : uv;
        mis = acc && ((a & (step - 32'h1)) != 32'h0);
        if (mis) begin
          s_d.aerr = 1'b1;
          s_d.eret = 1'b0;
        end else begin
          if (acc) begin
            s_d.req    = 1'b1;
            s_d.we     = st;
            s_d.addr   = a;
            s_d.size   = sz;
            s_d.wdata  = wd;
            s_d.ld_dst = dst;
            s_d.st     = cdm_pkg::ST_MEM;
          end
          if (wr || upd) begin
            s_d.wb_en   = 1'b1;
            s_d.wb_addr = ua;
            s_d.wb_data = uv;
          end
        end
      end
      cdm_pkg::ST_MEM: begin
        // load result lands before the next fetch completes
        if (i_bus_ack) begin
          s_d.req = 1'b0;
          s_d.st  = cdm_pkg::ST_FETCH;
          if (s_q.eret) begin
            s_d.pc   = i_bus_rdata;
            s_d.req  = 1'b1;
            s_d.addr = s_q.addr + cdm_pkg::POP_STEP;
            s_d.st   = cdm_pkg::ST_POP2;
          end else if (!s_q.we) begin
            s_d.wb_en   = 1'b1;
            s_d.wb_addr = s_q.ld_dst;
            s_d.wb_data = ld_ext;
          end
        end
      end
      cdm_pkg::ST_POP2: begin
        // second pop restores the flag and releases the stack slots
        if (i_bus_ack) begin
          s_d.req     = 1'b0;
          s_d.eret    = 1'b0;
          s_d.t       = i_bus_rdata[0];
          s_d.wb_en   = 1'b1;
          s_d.wb_addr = cdm_pkg::REG_STACK;
          s_d.wb_data = s_q.addr + cdm_pkg::POP_STEP;
          s_d.st      = cdm_pkg::ST_FETCH;
        end
      end
      cdm_pkg::ST_SLEEP: begin
        if (i_wake) begin
          s_d.sleep = 1'b0;
          s_d.st    = cdm_pkg::ST_FETCH;
        end
      end
      default: begin
        s_d.st = cdm_pkg::ST_FETCH;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q    <= '0;
      s_q.st <= cdm_pkg::ST_FETCH;
      s_q.pc <= RESET_PC;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign o_bus_req   = s_q.req;
  assign o_bus_we    = s_q.we;
  assign o_bus_addr  = s_q.addr;
  assign o_bus_size  = s_q.size;
  assign o_bus_wdata = s_q.wdata;
  assign o_pc        = s_q.pc;
  assign o_t_flag    = s_q.t;
  assign o_sleep     = s_q.sleep;
  assign o_addr_err  = s_q.aerr;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  // a pending request holds address and size until acked
  bus_hold_a: assert property (
    o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr)
    && $stable(o_bus_size))
    else $error("bus request dropped or changed before ack");

  // every request is aligned to its size
  bus_align_a: assert property (
    o_bus_req |-> (o_bus_addr & ((32'h1 << o_bus_size) - 32'h1)) == 32'h0)
    else $error("misaligned bus request");

  // move-immediate writes the sign-extended literal at once
  imm_sext_a: assert property (
    s_q.st == cdm_pkg::ST_EXEC && top == cdm_pkg::OP_IMM |-> s_d.wb_en
    && s_d.wb_addr == fn && s_d.wb_data == {{24{s_q.ir[7]}}, s_q.ir[7:0]})
    else $error("immediate move wrote wrong value");

  // register move finishes in one execution state
  one_state_a: assert property (
    s_q.st == cdm_pkg::ST_EXEC && top == cdm_pkg::OP_LDI
    && flo == cdm_pkg::LO_MOVR |=> s_q.st == cdm_pkg::ST_FETCH && !o_bus_req)
    else $error("register move took more than one state");

  // data moves do not touch the flag
  flag_keep_a: assert property (
    s_q.st == cdm_pkg::ST_EXEC && top != cdm_pkg::OP_IDX |=> $stable(o_t_flag))
    else $error("data move changed the flag");

  // pre-decrement store writes the reduced address back and uses it
  predec_a: assert property (
    s_q.st == cdm_pkg::ST_EXEC && top == cdm_pkg::OP_STI
    && flo == 4'h6 && dst_v[1:0] == 2'h0 |-> s_d.wb_en && s_d.wb_addr == fn
    && s_d.wb_data == dst_v - 32'h4 ##1 o_bus_addr == $past(dst_v) - 32'h4)
    else $error("pre-decrement store address wrong");

  // a completed load writes its own destination, after any increment
  load_wb_a: assert property (
    s_q.st == cdm_pkg::ST_MEM && i_bus_ack && !s_q.we && !s_q.eret
    |-> s_d.wb_en && s_d.wb_addr == s_q.ld_dst && s_d.wb_data == ld_ext)
    else $error("load result not written to destination");

  // word displacement loads go to register zero
  disp_r0_a: assert property (
    s_q.st == cdm_pkg::ST_EXEC && top == cdm_pkg::OP_DBW
    && fn == cdm_pkg::DBW_LDW && !s_d.aerr |=> s_q.ld_dst == 4'h0
    && o_bus_size == cdm_pkg::SZ_W)
    else $error("displacement load not aimed at register zero");

  // power-down is entered the cycle after the sleep code, with no bus request
  sleep_a: assert property (
    s_q.st == cdm_pkg::ST_EXEC && s_q.ir == cdm_pkg::SYS_SLEEP
    |=> o_sleep && !o_bus_req)
    else $error("power-down not entered");
endmodule

// file: verilog/cdm_pkg.sv
// constants shared by the data-move core and its load path; the register file takes its own parameters
// assumes one clock and a single shared memory bus for fetches and data
package cdm_pkg;
  localparam int XLEN = 32;
  localparam int IW   = 16;
  localparam int RAW  = 4;

  // instruction field positions (top bit of each field)
  localparam int F_TOP = 15;
  localparam int F_N   = 11;
  localparam int F_M   = 7;
  localparam int F_LO  = 3;

  // access sizes, shift amount equals size code
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_W = 2'h1;
  localparam logic [1:0] SZ_L = 2'h2;

  // upper nibble groups
  localparam logic [3:0] OP_IDX  = 4'h0;
  localparam logic [3:0] OP_STLD = 4'h1;
  localparam logic [3:0] OP_STI  = 4'h2;
  localparam logic [3:0] OP_LDLD = 4'h5;
  localparam logic [3:0] OP_LDI  = 4'h6;
  localparam logic [3:0] OP_DBW  = 4'h8;
  localparam logic [3:0] OP_PCW  = 4'h9;
  localparam logic [3:0] OP_PCL  = 4'hd;
  localparam logic [3:0] OP_IMM  = 4'he;

  // low nibble groups; DBW codes decode the F_N field
  localparam logic [1:0] LG_PLAIN = 2'h0;
  localparam logic [1:0] LG_STEP  = 2'h1;
  localparam logic [1:0] LG_IDXLD = 2'h3;
  localparam logic [3:0] LO_MOVR  = 4'h3;
  localparam logic [3:0] DBW_STB  = 4'h0;
  localparam logic [3:0] DBW_STW  = 4'h1;
  localparam logic [3:0] DBW_LDB  = 4'h4;
  localparam logic [3:0] DBW_LDW  = 4'h5;

  // system control codes
  localparam logic [15:0] SYS_IDLE  = 16'h0009;
  localparam logic [15:0] SYS_TCLR  = 16'h0008;
  localparam logic [15:0] SYS_TSET  = 16'h0018;
  localparam logic [15:0] SYS_SLEEP = 16'h001b;
  localparam logic [15:0] SYS_ERET  = 16'h002b;

  localparam logic [3:0]  REG_ZERO  = 4'h0;
  localparam logic [3:0]  REG_STACK = 4'hf;
  localparam logic [31:0] PC_OFS    = 32'h0000_0004;
  localparam logic [31:0] INSN_STEP = 32'h0000_0002;
  localparam logic [31:0] POP_STEP  = 32'h0000_0004;
  localparam logic [31:0] LONG_MASK = 32'hffff_fffc;
  localparam logic [31:0] RESET_PC  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_FETCH,
    ST_EXEC,
    ST_MEM,
    ST_POP2,
    ST_SLEEP
  } cdm_state_t;
endpackage

// file: verilog/cdm_reg_file.sv
// sixteen general registers, three registered read ports, one write port
// assumes reads and writes are never requested for the same cycle
`timescale 1ns/1ps
module cdm_reg_file #(
  parameter int WIDTH = 32,
  parameter int AW    = 4,
  parameter int NRD   = 3
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire logic               i_rd_en,
  input  wire logic [NRD*AW-1:0]  i_rd_addr,
  output logic      [NRD*WIDTH-1:0] o_rd_data,
  input  wire logic               i_wr_en,
  input  wire logic [AW-1:0]      i_wr_addr,
  input  wire logic [WIDTH-1:0]   i_wr_data
);
  logic [WIDTH-1:0] mem_q [2**AW];

  // register number selects the entry directly
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  // one registered read per port
  genvar g;
  generate
    for (g = 0; g < NRD; g++) begin : g_rd
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          o_rd_data[g*WIDTH +: WIDTH] <= '0;
        end else if (i_rd_en) begin
          o_rd_data[g*WIDTH +: WIDTH] <= mem_q[i_rd_addr[g*AW +: AW]];
        end
      end
    end
  endgenerate
endmodule
